// *** xbp_bus.sv ***
module xbp_bus
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic reset_pin_in,
    input wire logic double_speed_mode_in,
    input wire logic external_fetch_select_in,
    input wire logic validation_mode_in,
    input wire logic ale_disable_in,
    // Core request for one machine cycle access
    input wire logic req_valid_in,
    input wire xbp_pkg::xbp_op_e req_op_in,
    input wire logic req_wide_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [7:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [7:0] rsp_rdata_out,
    // Port latches written by the core
    input wire logic [7:0] upper_port_latch_in,
    input wire logic [7:0] p3_latch_in,
    input wire logic [4:0] p4_latch_in,
    // Alternate function outputs from peripherals
    input wire logic serial_tx_in,
    input wire logic serial_rx_out_in,
    input wire logic serial_rx_oe_in,
    input wire logic can_tx_in,
    input wire logic spi_miso_in,
    input wire logic spi_sck_in,
    input wire logic spi_mosi_in,
    // Alternate function inputs to peripherals
    output logic serial_rx_out,
    output logic external_interrupt_zero_out,
    output logic external_interrupt_one_out,
    output logic timer_zero_count_input_out,
    output logic timer_one_count_input_out,
    output logic can_receive_out,
    output logic [4:0] p4_pin_value_out,
    output logic [7:0] p3_pin_value_out,
    output logic [7:0] upper_pin_value_out,
    output logic device_reset_out,
    // Pins
    input wire logic [7:0] p0_pin_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe_out,
    input wire logic [7:0] p2_pin_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_out,
    input wire logic [7:0] p3_pin_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe_out,
    input wire logic [4:0] p4_pin_in,
    output logic [4:0] p4_out,
    output logic [4:0] p4_oe_out,
    output logic address_latch_out,
    output logic program_fetch_strobe_n_out
);
    import xbp_pkg::*;

    typedef struct packed
    {
        xbp_bus_e st;
        xbp_op_e op;
        logic wide;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic rsp;
        logic ale;
        logic program_fetch_strobe_n;
        logic [7:0] p0;
        logic [7:0] p0_oe;
        logic [7:0] p2;
        logic [7:0] p2_oe;
        logic wr_n;
        logic rd_n;
        logic [7:0] p0_s1;
        logic [7:0] p0_s2;
        logic [7:0] p2_s1;
        logic [7:0] p2_s2;
        logic [7:0] p3_s1;
        logic [7:0] p3_s2;
        logic [4:0] p4_s1;
        logic [4:0] p4_s2;
        logic [1:0] ea_s;
    } xbp_bus_s;

    xbp_bus_s r;
    xbp_bus_s next_r;
    xbp_timing_if tim();

    // ****************************************
    // Helpers
    // ****************************************
    // Scale a standard-mode phase to the active mode
    function automatic logic at_phase(input logic [3:0] ph, input logic [3:0] pos, input logic x2);
        at_phase = x2 ? (ph == (pos >> 1)) : (ph == pos);
    endfunction

    function automatic logic in_window(input logic [3:0] ph, input logic [3:0] pos, input logic x2);
        logic [3:0] start;
        logic [3:0] len;
        start = x2 ? (pos >> 1) : pos;
        len = x2 ? 4'h2 : FETCH_LEN;
        in_window = (ph >= start) && (ph < start + len);
    endfunction

    assign tim.double_speed_mode = double_speed_mode_in;

    xbp_timing u_timing
    (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .reset_pin_in(reset_pin_in),
        .tim(tim.gen)
    );

    logic ext_fetch;
    logic data_cycle;
    logic ale_slot0;
    logic ale_slot1;
    logic fetch_slot;
    logic mid_cycle;

    // ****************************************
    // Bus sequencing
    // ****************************************
    always_comb
    begin
        next_r = r;
        // Pin synchronisers
        next_r.p0_s1 = p0_pin_in;
        next_r.p0_s2 = r.p0_s1;
        next_r.p2_s1 = p2_pin_in;
        next_r.p2_s2 = r.p2_s1;
        next_r.p3_s1 = p3_pin_in;
        next_r.p3_s2 = r.p3_s1;
        next_r.p4_s1 = p4_pin_in;
        next_r.p4_s2 = r.p4_s1;
        next_r.ea_s = {r.ea_s[0], external_fetch_select_in};
        next_r.rsp = 1'b0;

        ext_fetch = !r.ea_s[1];
        // Bus is released at the cycle end, so the closing state is not a data cycle
        data_cycle = ((r.st == XBP_ADDR) || (r.st == XBP_DATA)) && (r.op != XBP_OP_FETCH);
        ale_slot0 = at_phase(tim.phase, ALE_PH0, double_speed_mode_in);
        ale_slot1 = at_phase(tim.phase, ALE_PH1, double_speed_mode_in);
        mid_cycle = ale_slot1;
        fetch_slot = in_window(tim.phase, FETCH_PH0, double_speed_mode_in)
                     || in_window(tim.phase, FETCH_PH1, double_speed_mode_in);

        // Address strobe twice per machine cycle; data access keeps only its own
        next_r.ale = 1'b0;
        if (!(ale_disable_in && !ext_fetch))
        begin
            if (data_cycle)
                next_r.ale = ale_slot0 && (r.st == XBP_ADDR);
            else
                next_r.ale = ale_slot0 || ale_slot1;
        end

        // Fetch strobe only for external fetches, not during data cycles
        next_r.program_fetch_strobe_n = !(ext_fetch && !data_cycle && fetch_slot);

        // Data access state machine, one machine cycle per access
        case (r.st)
            XBP_IDLE:
            begin
                next_r.p0_oe = 8'h00;
                next_r.p2_oe = 8'h00;
                next_r.wr_n = 1'b1;
                next_r.rd_n = 1'b1;
                if (req_valid_in && tim.cycle_end)
                begin
                    next_r.st = XBP_ADDR;
                    next_r.op = req_op_in;
                    next_r.wide = req_wide_in || (req_op_in == XBP_OP_FETCH);
                    next_r.addr = req_addr_in;
                    next_r.wdata = req_wdata_in;
                end
            end
            XBP_ADDR:
            begin
                // Low address on first port while strobe latches it
                next_r.p0 = r.addr[7:0];
                next_r.p0_oe = 8'hff;
                next_r.p2 = r.wide ? r.addr[15:8] : upper_port_latch_in;
                next_r.p2_oe = r.wide ? 8'hff : ~upper_port_latch_in;
                if (at_phase(tim.phase, FETCH_PH0, double_speed_mode_in))
                    next_r.st = XBP_DATA;
            end
            XBP_DATA:
            begin
                if (r.op == XBP_OP_WRITE)
                begin
                    next_r.p0 = r.wdata;
                    next_r.p0_oe = 8'hff;
                    next_r.wr_n = 1'b0;
                end
                else
                begin
                    next_r.p0_oe = 8'h00;
                    next_r.rd_n = (r.op != XBP_OP_READ);
                end
                if (tim.cycle_end)
                begin
                    next_r.rdata = r.p0_s2;
                    next_r.st = XBP_DONE;
                end
                else if (mid_cycle && r.op == XBP_OP_FETCH)
                begin
                    next_r.rdata = r.p0_s2;
                end
            end
            XBP_DONE:
            begin
                next_r.wr_n = 1'b1;
                next_r.rd_n = 1'b1;
                next_r.rsp = 1'b1;
                next_r.st = XBP_IDLE;
            end
            default:
            begin
                next_r.st = XBP_IDLE;
            end
        endcase

        // Validation mode: second port input only
        if (validation_mode_in)
            next_r.p2_oe = 8'h00;
        if (tim.in_reset)
        begin
            next_r.st = XBP_IDLE;
            next_r.p0_oe = 8'h00;
            next_r.p2_oe = 8'h00;
            next_r.wr_n = 1'b1;
            next_r.rd_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r <= '0;
            r.program_fetch_strobe_n <= 1'b1;
            r.wr_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.p2 <= LATCH_RESET;
            r.ea_s <= 2'h3;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************
    // Port pins
    // ****************************************
    assign req_ready_out = (r.st == XBP_IDLE) && tim.cycle_end && !tim.in_reset;
    assign rsp_valid_out = r.rsp;
    assign rsp_rdata_out = r.rdata;
    assign address_latch_out = r.ale;
    assign program_fetch_strobe_n_out = r.program_fetch_strobe_n;
    assign device_reset_out = tim.in_reset;
    assign p0_out = r.p0;
    assign p0_oe_out = r.p0_oe;
    // Bus cycle owns the second port, otherwise quasi-bidirectional latch
    assign p2_out = (r.st != XBP_IDLE) ? r.p2 : upper_port_latch_in;
    assign p2_oe_out = (r.st != XBP_IDLE) ? r.p2_oe
                       : (validation_mode_in ? 8'h00 : ~upper_port_latch_in);
    assign upper_pin_value_out = r.p2_s2;

    // Third port: drive low only when latch or alternate output is zero
    always_comb
    begin
        p3_out = 8'h00;
        p3_oe_out = ~p3_latch_in;
        p3_oe_out[P3_TXD] = !(p3_latch_in[P3_TXD] && serial_tx_in);
        p3_oe_out[P3_RXD] = !p3_latch_in[P3_RXD] || (serial_rx_oe_in && !serial_rx_out_in);
        p3_oe_out[P3_WR] = !(p3_latch_in[P3_WR] && r.wr_n);
        p3_oe_out[P3_RD] = !(p3_latch_in[P3_RD] && r.rd_n);
    end
    assign p3_pin_value_out = r.p3_s2;
    // Alternate inputs gated by latch one
    assign serial_rx_out = r.p3_s2[P3_RXD] | ~p3_latch_in[P3_RXD];
    assign external_interrupt_zero_out = r.p3_s2[P3_EXTERNAL_INTERRUPT_ZERO] | ~p3_latch_in[P3_EXTERNAL_INTERRUPT_ZERO];
    assign external_interrupt_one_out = r.p3_s2[P3_EXTERNAL_INTERRUPT_ONE] | ~p3_latch_in[P3_EXTERNAL_INTERRUPT_ONE];
    assign timer_zero_count_input_out = r.p3_s2[P3_T0] & p3_latch_in[P3_T0];
    assign timer_one_count_input_out = r.p3_s2[P3_T1] & p3_latch_in[P3_T1];

    // Fourth port
    always_comb
    begin
        p4_out = 5'h00;
        p4_oe_out = ~p4_latch_in;
        p4_oe_out[P4_CTX] = !(p4_latch_in[P4_CTX] && can_tx_in);
        p4_oe_out[P4_MISO] = !(p4_latch_in[P4_MISO] && spi_miso_in);
        p4_oe_out[P4_SCK] = !(p4_latch_in[P4_SCK] && spi_sck_in);
        p4_oe_out[P4_MOSI] = !(p4_latch_in[P4_MOSI] && spi_mosi_in);
    end
    assign can_receive_out = r.p4_s2[P4_CRX] | ~p4_latch_in[P4_CRX];
    assign p4_pin_value_out = r.p4_s2;
endmodule

// *** xbp_pkg.sv ***
package xbp_pkg;
    // ****************************************
    // Timing constants
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int STD_PERIODS = 12;                  // Oscillator periods per machine cycle
    localparam int X2_PERIODS = 6;                    // Same in double-speed mode
    localparam int RESET_HOLD_CYCLES = 2;             // Machine cycles reset pin must stay high
    localparam logic [3:0] PHASE_RESET = 4'h0;
    localparam logic [7:0] LATCH_RESET = 8'hff;       // Port latches come up as ones
    localparam logic [4:0] P4_RESET = 5'h1f;
    // Phase positions of strobe events within a standard machine cycle
    localparam logic [3:0] ALE_PH0 = 4'h0;
    localparam logic [3:0] ALE_PH1 = 4'h6;
    localparam logic [3:0] FETCH_PH0 = 4'h2;
    localparam logic [3:0] FETCH_PH1 = 4'h8;
    localparam logic [3:0] FETCH_LEN = 4'h3;

    // Third-port bit positions
    localparam int P3_RXD = 0;
    localparam int P3_TXD = 1;
    localparam int P3_EXTERNAL_INTERRUPT_ZERO = 2;
    localparam int P3_EXTERNAL_INTERRUPT_ONE = 3;
    localparam int P3_T0 = 4;
    localparam int P3_T1 = 5;
    localparam int P3_WR = 6;
    localparam int P3_RD = 7;
    // Fourth-port bit positions
    localparam int P4_CTX = 0;
    localparam int P4_CRX = 1;
    localparam int P4_MISO = 2;
    localparam int P4_SCK = 3;
    localparam int P4_MOSI = 4;

    typedef enum logic [1:0]
    {
        XBP_IDLE = 2'b00,
        XBP_ADDR = 2'b01,
        XBP_DATA = 2'b11,
        XBP_DONE = 2'b10
    } xbp_bus_e;

    typedef enum logic [1:0]
    {
        XBP_OP_FETCH = 2'h0,
        XBP_OP_READ = 2'h1,
        XBP_OP_WRITE = 2'h2
    } xbp_op_e;
endpackage

// *** xbp_timing_if.sv ***
interface xbp_timing_if;
    logic double_speed_mode;
    logic [3:0] phase;
    logic cycle_end;
    logic in_reset;

    modport gen
    (
        input double_speed_mode,
        output phase,
        output cycle_end,
        output in_reset
    );
    modport use_side
    (
        output double_speed_mode,
        input phase,
        input cycle_end,
        input in_reset
    );
endinterface

// *** xbp_timing.sv ***
module xbp_timing
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic reset_pin_in,
    xbp_timing_if.gen tim
);
    import xbp_pkg::*;

    typedef struct packed
    {
        logic [3:0] phase;
        logic [1:0] rst_cnt;
        logic in_reset;
        logic [1:0] rst_sync;
    } xbp_tim_s;

    xbp_tim_s r;
    xbp_tim_s next_r;
    logic last_phase;

    // ****************************************
    // Machine cycle counter and reset pin filter
    // ****************************************
    always_comb
    begin
        next_r = r;
        next_r.rst_sync = {r.rst_sync[0], reset_pin_in};
        // Cycle length: 12 or 6 oscillator periods
        last_phase = tim.double_speed_mode ? (r.phase >= 4'(X2_PERIODS - 1))
                                           : (r.phase >= 4'(STD_PERIODS - 1));
        next_r.phase = last_phase ? 4'h0 : r.phase + 4'h1;
        if (last_phase)
        begin
            // Pin high for two whole machine cycles enters reset
            if (!r.rst_sync[1])
            begin
                next_r.rst_cnt = 2'h0;
                next_r.in_reset = 1'b0;
            end
            // First cycle end may close a partial cycle, so count one more
            else if (r.rst_cnt >= 2'(RESET_HOLD_CYCLES))
                next_r.in_reset = 1'b1;
            else
                next_r.rst_cnt = r.rst_cnt + 2'h1;
        end
        else if (!r.rst_sync[1])
        begin
            next_r.rst_cnt = 2'h0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            r <= '0;
        else
            r <= next_r;
    end

    assign tim.phase = r.phase;
    assign tim.cycle_end = last_phase;
    assign tim.in_reset = r.in_reset;
endmodule

// *** xbp_ext_mem.sv ***
module xbp_ext_mem
(
    input wire logic clk_in,
    input wire logic ale_in,
    input wire logic [7:0] p0_in,
    input wire logic [7:0] p2_in,
    input wire logic wr_n_in,
    input wire logic rd_n_in,
    input wire logic program_fetch_strobe_n_in,
    output logic [7:0] p0_drive_out,
    output logic [7:0] hi_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // External memory model
    // ****************************************
    logic [7:0] mem [0:255];
    logic [7:0] lo;
    logic [7:0] idle = 8'ha5;
    // Low address taken as the strobe falls
    always @(negedge ale_in)
    begin
        lo <= p0_in;
    end
    // Write data and upper address taken while a strobe is low
    always @(posedge clk_in)
    begin
        if (!wr_n_in)
            mem[lo] <= p0_in;
        if (!wr_n_in || !rd_n_in)
            hi_out <= p2_in;
        idle <= ~idle;
    end
    // Bus driven only under read or fetch strobe, else a moving pattern
    assign p0_drive_out = !rd_n_in ? mem[lo] : (!program_fetch_strobe_n_in ? ~lo : idle);
endmodule

// *** xbp_bus_monitor.sv ***
module xbp_bus_monitor
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic reset_pin_in,
    input wire logic double_speed_mode_in,
    input wire logic external_fetch_select_in,
    input wire logic validation_mode_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [7:0] p3_latch_in,
    input wire logic [4:0] p4_latch_in,
    input wire logic external_interrupt_zero_out,
    input wire logic can_receive_out,
    input wire logic device_reset_out,
    input wire logic [7:0] p0_oe_out,
    input wire logic [7:0] p2_oe_out,
    input wire logic [7:0] p3_oe_out,
    input wire logic address_latch_out,
    input wire logic program_fetch_strobe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Pin timing checks
    // ****************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    AST_ALE_GAP: assert property (address_latch_out && !double_speed_mode_in |=> !address_latch_out [*5])
        else $error("address strobe too frequent");
    AST_ALE_GAP_X2: assert property (address_latch_out && double_speed_mode_in |=> !address_latch_out [*2])
        else $error("address strobe too frequent in double speed");
    AST_PROGRAM_FETCH_STROBE_LEN: assert property ($fell(program_fetch_strobe_n_out) && !double_speed_mode_in
        |-> !program_fetch_strobe_n_out [*3] ##1 program_fetch_strobe_n_out)
        else $error("fetch strobe width wrong");
    AST_NO_INT_FETCH: assert property (external_fetch_select_in && $past(external_fetch_select_in, 8)
        |-> program_fetch_strobe_n_out)
        else $error("fetch strobe during internal fetch");
    AST_STROBE_EXCL: assert property (p3_latch_in[7:6] == 2'b11 |-> !(p3_oe_out[6] && p3_oe_out[7]))
        else $error("read and write strobes together");
    AST_WR_DATA: assert property (p3_latch_in[6] && p3_oe_out[6] |-> p0_oe_out == 8'hff)
        else $error("data bus not driven during write");
    AST_RD_QUIET: assert property (p3_latch_in[7] && p3_oe_out[7]
        |-> program_fetch_strobe_n_out && !address_latch_out && p0_oe_out == 8'h00)
        else $error("bus activity during read");
    AST_RSP_STD: assert property (req_valid_in && req_ready_out && !double_speed_mode_in |-> ##14 rsp_valid_out)
        else $error("response late in standard mode");
    AST_RSP_X2: assert property (req_valid_in && req_ready_out && double_speed_mode_in |-> ##8 rsp_valid_out)
        else $error("response late in double speed");
    AST_VALID_IN: assert property (validation_mode_in && $past(validation_mode_in, 2) |-> p2_oe_out == 8'h00)
        else $error("second port driven in validation");
    AST_EXTERNAL_INTERRUPT_ZERO_GATE: assert property (!p3_latch_in[2] && !$past(p3_latch_in[2], 3) |-> external_interrupt_zero_out)
        else $error("interrupt input not gated");
    AST_CAN_GATE: assert property (!p4_latch_in[1] && !$past(p4_latch_in[1], 3) |-> can_receive_out)
        else $error("can receive not gated");
    AST_RESET_HOLD: assert property ($rose(device_reset_out) && !double_speed_mode_in
        |-> $past(reset_pin_in, 22) && $past(reset_pin_in, 3))
        else $error("device reset without long pin hold");
endmodule
bind xbp_bus xbp_bus_monitor mon (.*);

// *** xbp_testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import xbp_pkg::*;
    // ****************************************
    // Signals and pins
    // ****************************************
    logic sys_clk_in, reset_n_in, reset_pin_in, double_speed_mode_in, external_fetch_select_in;
    logic validation_mode_in, ale_disable_in, req_valid_in, req_wide_in, req_ready_out, rsp_valid_out;
    xbp_op_e req_op_in;
    logic [15:0] req_addr_in;
    logic [7:0] req_wdata_in, rsp_rdata_out, upper_port_latch_in, p3_latch_in, p3_pin_value_out, upper_pin_value_out;
    logic [4:0] p4_latch_in, p4_pin_value_out, p4_pin_in, p4_out, p4_oe_out, ext4;
    logic serial_tx_in, serial_rx_out_in, serial_rx_oe_in, can_tx_in, spi_miso_in, spi_sck_in, spi_mosi_in;
    logic serial_rx_out, external_interrupt_zero_out, external_interrupt_one_out, timer_zero_count_input_out;
    logic timer_one_count_input_out, can_receive_out, device_reset_out, address_latch_out, program_fetch_strobe_n_out;
    logic [7:0] p0_pin_in, p0_out, p0_oe_out, p2_pin_in, p2_out, p2_oe_out, p3_pin_in, p3_out, p3_oe_out;
    logic [7:0] ext2, ext3, mem_d, hi, q;
    int errors, comparisons;
    // Wire levels from all drivers, pull-ups on ports 2 to 4
    assign p0_pin_in = (p0_oe_out & p0_out) | (~p0_oe_out & mem_d);
    assign p2_pin_in = (p2_oe_out & p2_out) | (~p2_oe_out & ext2);
    assign p3_pin_in = (p3_oe_out & p3_out) | (~p3_oe_out & ext3);
    assign p4_pin_in = (p4_oe_out & p4_out) | (~p4_oe_out & ext4);
    xbp_bus dut (.*);
    xbp_ext_mem ext_mem (.clk_in(sys_clk_in), .ale_in(address_latch_out), .p0_in(p0_pin_in), .p2_in(p2_pin_in),
        .wr_n_in(p3_pin_in[6]), .rd_n_in(p3_pin_in[7]), .program_fetch_strobe_n_in(program_fetch_strobe_n_out),
        .p0_drive_out(mem_d), .hi_out(hi));
    // Clock generator
    initial
    begin
        sys_clk_in = 0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        $display("counts errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task automatic do_reset(input logic x2);
        reset_n_in = 0;
        double_speed_mode_in = x2;
        wait_n(2);
        reset_n_in = 1;
        wait_n(4);
    endtask
    task automatic access(input xbp_op_e o, input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 50)
        begin
            wait_n(1);
            n++;
        end
        req_valid_in = 1;
        req_op_in = o;
        req_wide_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        @(posedge sys_clk_in);
        wait_n(1);
        req_valid_in = 0;
        n = 0;
        while (rsp_valid_out !== 1'b1 && n < 50)
        begin
            wait_n(1);
            n++;
        end
        q = rsp_rdata_out;
        if (n == 50)
            check(8'h00, 8'h01);
    endtask
    task automatic count(input int len, output int f, output int a);
        logic p;
        f = 0;
        a = 0;
        p = program_fetch_strobe_n_out;
        repeat (len)
        begin
            wait_n(1);
            f += (p && !program_fetch_strobe_n_out);
            a += address_latch_out;
            p = program_fetch_strobe_n_out;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_bus();
        access(XBP_OP_WRITE, 1, 16'h12a5, 8'h3c);
        check(ext_mem.mem[8'ha5], 8'h3c);
        check(hi, 8'h12);
        access(XBP_OP_READ, 1, 16'h34a5, 8'h00);
        check(q, 8'h3c);
        check(hi, 8'h34);
        upper_port_latch_in = 8'h5a;
        access(XBP_OP_WRITE, 0, 16'h0077, 8'hc3);
        check(hi, 8'h5a);
        check(ext_mem.mem[8'h77], 8'hc3);
        $display("test bus done");
    endtask
    task automatic t_fetch();
        int f, a;
        external_fetch_select_in = 0;
        do_reset(0);
        count(48, f, a);
        check(8'(f), 8'd8);
        fork
            count(48, f, a);
            access(XBP_OP_READ, 1, 16'h0277, 8'h00);
        join
        check(8'(f), 8'd6);
        check(8'(a), 8'd7);
        check(q, 8'hc3);
        external_fetch_select_in = 1;
        do_reset(0);
        count(48, f, a);
        check(8'(f), 8'd0);
        $display("test fetch done");
    endtask
    task automatic t_ale();
        int f, a;
        count(48, f, a);
        check(8'(a), 8'd8);
        ale_disable_in = 1;
        wait_n(4);
        count(48, f, a);
        check(8'(a), 8'd0);
        ale_disable_in = 0;
        do_reset(1);
        count(48, f, a);
        check(8'(a), 8'd16);
        access(XBP_OP_READ, 1, 16'h56a5, 8'h00);
        check(q, 8'h3c);
        do_reset(0);
        $display("test strobe rate done");
    endtask
    task automatic t_pins();
        validation_mode_in = 1;
        ext2 = 8'h96;
        wait_n(4);
        check(p2_oe_out, 8'h00);
        check(upper_pin_value_out, 8'h96);
        validation_mode_in = 0;
        ext2 = 8'hff;
        ext3 = 8'hea;
        wait_n(4);
        check(p3_pin_value_out, 8'hea);
        check(8'({timer_one_count_input_out, timer_zero_count_input_out, external_interrupt_one_out,
            external_interrupt_zero_out, serial_rx_out}), 8'h14);
        p3_latch_in = 8'hc0;
        wait_n(4);
        check(8'({timer_one_count_input_out, timer_zero_count_input_out, external_interrupt_one_out,
            external_interrupt_zero_out}), 8'h03);
        p3_latch_in = 8'hff;
        ext3 = 8'hff;
        ext4 = 5'h1d;
        can_tx_in = 0;
        wait_n(4);
        check(8'(p4_pin_value_out), 8'h1c);
        check(8'(can_receive_out), 8'h00);
        p4_latch_in = 5'h1d;
        wait_n(4);
        check(8'(can_receive_out), 8'h01);
        p4_latch_in = 5'h1f;
        ext4 = 5'h1f;
        can_tx_in = 1;
        $display("test pins done");
    endtask
    task automatic t_rst();
        reset_pin_in = 1;
        wait_n(12);
        reset_pin_in = 0;
        wait_n(30);
        check(8'(device_reset_out), 8'h00);
        reset_pin_in = 1;
        wait_n(40);
        check(8'(device_reset_out), 8'h01);
        reset_pin_in = 0;
        wait_n(40);
        $display("test reset pin done");
    endtask
    // Watchdog against a hang
    initial
    begin
        #800000;
        errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        {reset_n_in, reset_pin_in, double_speed_mode_in, validation_mode_in, ale_disable_in} = 5'h00;
        {req_valid_in, req_wide_in, req_addr_in, req_wdata_in, upper_port_latch_in} = '0;
        req_op_in = XBP_OP_FETCH;
        external_fetch_select_in = 1;
        {p3_latch_in, ext2, ext3, p4_latch_in, ext4} = {8'hff, 8'hff, 8'hff, 5'h1f, 5'h1f};
        {serial_tx_in, serial_rx_out_in, serial_rx_oe_in, can_tx_in} = 4'h9;
        {spi_miso_in, spi_sck_in, spi_mosi_in} = 3'h7;
        errors = 0;
        comparisons = 0;
        wait_n(2);
        reset_n_in = 1;
        wait_n(4);
        t_bus();
        t_fetch();
        t_ale();
        t_pins();
        t_rst();
        finish_test();
    end
endmodule
